// File: rtl/paired_timer_32bit.sv
/*
 * Four 16-bit timers in two pairs, each pair joinable into one 32-bit
 * timer, with AXI4-Lite registers, sticky match status and one
 * level interrupt. Assumes external count and gate pins are asynchronous
 * to mclk; both are synchronised here, and the count pins edge-detected.
 */
module paired_timer_32bit (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // AXI4-Lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // AXI4-Lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Pins: external count inputs and gate inputs, one per timer
    input  wire logic [3:0]  extCount,
    input  wire logic [3:0]  extGate,
    // Events
    output logic             adcTrigger,
    output logic             irq,
    output logic [2:0]       irqPriority
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [15:0] ctrlQ   [4];     // Control per timer
    logic [15:0] periodQ [4];     // Period per timer
    logic [15:0] countQ  [4];     // Count per timer
    logic [15:0] countD  [4];     // Next count
    logic [3:0]  statusQ;         // Sticky match flags
    logic [3:0]  maskQ;           // Interrupt enables
    logic [11:0] prioQ;           // Three-bit priority per timer
    logic [7:0]  preQ    [4];     // Prescale counters
    logic [7:0]  preD    [4];
    logic [3:0]  matchEv;         // Period match events this cycle
    logic        adcQ;            // Registered converter trigger

    // ------------------------------------------------------------------
    // Pin synchronisers: two flops, plus a third on count pins for edge detect
    // ------------------------------------------------------------------
    logic [3:0] cntS1Q, cntS2Q, cntS3Q;  // Count pin stages
    logic [3:0] gateS1Q, gateS2Q;        // Gate pin stages

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            // Idle-low reset level: no false edge after reset
            cntS1Q  <= 4'h0;
            cntS2Q  <= 4'h0;
            cntS3Q  <= 4'h0;
            gateS1Q <= 4'h0;
            gateS2Q <= 4'h0;
        end else begin
            cntS1Q  <= extCount;
            cntS2Q  <= cntS1Q;
            cntS3Q  <= cntS2Q;
            gateS1Q <= extGate;
            gateS2Q <= gateS1Q;
        end
    end

    // Rising edges of the synchronised count inputs
    wire [3:0] extRise = cntS2Q & ~cntS3Q;

    // ------------------------------------------------------------------
    // Effective configuration per timer
    // ------------------------------------------------------------------
    wire joinA = ctrlQ[0][paired_timer_pkg::JOIN_BIT];
    wire joinB = ctrlQ[2][paired_timer_pkg::JOIN_BIT];
    wire [3:0] joined = {joinB, joinB, joinA, joinA};

    logic [3:0] runOn;     // Timer enabled
    logic [3:0] tick;      // Prescaled tick
    logic [3:0] step;      // Tick that may advance the count
    logic [3:0] atPeriod;  // Count equals period

    // Paired 32-bit compare values, upper word from upper timer
    wire [31:0] cntA = {countQ[1], countQ[0]};
    wire [31:0] cntB = {countQ[3], countQ[2]};
    wire [31:0] perA = {periodQ[1], periodQ[0]};
    wire [31:0] perB = {periodQ[3], periodQ[2]};

    // ------------------------------------------------------------------
    // Tick generation per timer; upper timers of a joined pair take the
    // lower timer's control, clock and gate
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            int src;
            logic [15:0] c;
            logic [7:0]  lim;
            logic        raw;
            logic        gateOk;
            lim    = paired_timer_pkg::PS_DIV1;
            raw    = 1'b0;
            gateOk = 1'b0;

            src = (joined[i] && i[0]) ? i - 1 : i;
            c   = ctrlQ[src];
            unique case (c[paired_timer_pkg::PS_HI:paired_timer_pkg::PS_LO])
                2'd0:    lim = paired_timer_pkg::PS_DIV1;
                2'd1:    lim = paired_timer_pkg::PS_DIV8;
                2'd2:    lim = paired_timer_pkg::PS_DIV64;
                default: lim = paired_timer_pkg::PS_DIV256;
            endcase
            runOn[i] = c[paired_timer_pkg::ON_BIT];
            // Synchronous counter on pin edges, else the system clock
            raw = c[paired_timer_pkg::SRC_BIT] ? extRise[src] : 1'b1;
            // Gate mode counts only while the gate pin is high
            gateOk = !c[paired_timer_pkg::GATE_BIT] || gateS2Q[src];
            step[i] = 1'b0;
            tick[i] = 1'b0;
            preD[i] = preQ[i];
            if (runOn[i] && raw && gateOk) begin
                if (preQ[i] == lim) begin
                    tick[i] = 1'b1;
                    preD[i] = 8'h00;
                end else begin
                    preD[i] = preQ[i] + 8'h01;
                end
            end else if (!runOn[i]) begin
                // Stopped: prescaler restarts at zero
                preD[i] = 8'h00;
            end
            step[i] = tick[i];
        end
    end

    // ------------------------------------------------------------------
    // Count update: 16-bit wrap at period, or 32-bit wrap per pair
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            atPeriod[i] = (countQ[i] == periodQ[i]);
            countD[i]   = countQ[i];
            matchEv[i]  = 1'b0;
        end

        // Then apply each pair's steps
        for (int p = 0; p < 2; p++) begin
            int lo;
            logic [31:0] c32;
            logic [31:0] p32;
            lo  = 2 * p;
            c32 = p[0] ? cntB : cntA;
            p32 = p[0] ? perB : perA;
            if (joined[lo]) begin
                if (step[lo]) begin
                    if (c32 == p32) begin
                        // Both words wrap together
                        countD[lo]     = 16'h0000;
                        countD[lo + 1] = 16'h0000;
                        matchEv[lo + 1] = 1'b1;
                    end else begin
                        {countD[lo + 1], countD[lo]} = c32 + 32'h0000_0001;
                    end
                end
            end else begin
                // Split: each timer wraps at its own period
                for (int k = lo; k < lo + 2; k++) begin
                    if (step[k]) begin
                        if (atPeriod[k]) begin
                            countD[k]  = 16'h0000;
                            matchEv[k] = 1'b1;
                        end else begin
                            countD[k] = countQ[k] + 16'h0001;
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave: write takes address and data in either order
    // ------------------------------------------------------------------
    logic        awHeldQ, wHeldQ;
    logic [7:0]  awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0]  wStrbQ;

    // A half is refused while parked or while its answer waits
    assign awready = !awHeldQ && !bvalid;
    assign wready  = !wHeldQ && !bvalid;
    assign arready = !rvalid;

    // A parked half stands in for the live one
    wire        awGot   = awHeldQ || (awvalid && awready);
    wire        wGot    = wHeldQ || (wvalid && wready);
    wire        doWrite = awGot && wGot && !bvalid;
    wire [7:0]  wAddr   = awHeldQ ? awAddrQ : awaddr;
    wire [31:0] wVal    = wHeldQ ? wDataQ : wdata;
    wire [3:0]  wStb    = wHeldQ ? wStrbQ : wstrb;
    wire        wLoOk   = wStb[0] && wStb[1];           // Low halfword lanes
    wire        wMapped = (wAddr < paired_timer_pkg::ADDR_TOP) && (wAddr[1:0] == 2'b00);
    wire [1:0]  wIdx    = wAddr[3:2];
    wire        wCtrl   = wAddr[7:4] == paired_timer_pkg::CTRL_BASE[7:4];
    wire        wPer    = wAddr[7:4] == paired_timer_pkg::PERIOD_BASE[7:4];
    wire        wCnt    = wAddr[7:4] == paired_timer_pkg::COUNT_BASE[7:4];

    // Read side
    wire        doRead  = arvalid && arready;
    wire [1:0]  rIdx    = araddr[3:2];
    wire        rMapped = (araddr < paired_timer_pkg::ADDR_TOP) && (araddr[1:0] == 2'b00);
    wire        rStatus = rMapped && (araddr == paired_timer_pkg::IRQ_STATUS);
    logic [31:0] rMux;

    // Read data selection
    always_comb begin
        unique case (araddr[7:4])
            paired_timer_pkg::CTRL_BASE[7:4]:   rMux = {16'h0000, ctrlQ[rIdx]};
            paired_timer_pkg::PERIOD_BASE[7:4]: rMux = {16'h0000, periodQ[rIdx]};
            paired_timer_pkg::COUNT_BASE[7:4]:  rMux = {16'h0000, countQ[rIdx]};
            default: begin
                if (araddr == paired_timer_pkg::IRQ_STATUS)
                    rMux = {28'h000_0000, statusQ};
                else if (araddr == paired_timer_pkg::IRQ_MASK)
                    rMux = {28'h000_0000, maskQ};
                else
                    rMux = {20'h0_0000, prioQ};
            end
        endcase
    end

    // Bus handshake registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            awHeldQ <= 1'b0;
            wHeldQ  <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ  <= 32'h0000_0000;
            wStrbQ  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= paired_timer_pkg::RESP_OKAY;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= paired_timer_pkg::RESP_OKAY;
        end else begin
            // A lone half waits here for its partner
            if (awvalid && awready && !doWrite) begin
                awHeldQ <= 1'b1;
                awAddrQ <= awaddr;
            end

            if (wvalid && wready && !doWrite) begin
                wHeldQ <= 1'b1;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end

            // Both halves in: answer next cycle
            if (doWrite) begin
                awHeldQ <= 1'b0;
                wHeldQ  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wMapped ? paired_timer_pkg::RESP_OKAY
                                   : paired_timer_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end

            // Unmapped reads answer zero
            if (doRead) begin
                rvalid <= 1'b1;
                rdata  <= rMapped ? rMux : 32'h0000_0000;
                rresp  <= rMapped ? paired_timer_pkg::RESP_OKAY
                                  : paired_timer_pkg::RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Timer registers; a bus write to a count wins over counting
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                ctrlQ[i]   <= paired_timer_pkg::CTRL_RESET;
                periodQ[i] <= paired_timer_pkg::PERIOD_RESET;
                countQ[i]  <= 16'h0000;
                preQ[i]    <= 8'h00;
            end
            maskQ <= 4'h0;
            prioQ <= 12'h000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                preQ[i]  <= preD[i];
                countQ[i] <= countD[i];
            end

            // Count writes come last, so the bus wins
            if (doWrite && wMapped && wLoOk) begin
                if (wCtrl)
                    ctrlQ[wIdx] <= wVal[15:0] & paired_timer_pkg::CTRL_MASK;
                if (wPer)
                    periodQ[wIdx] <= wVal[15:0];
                if (wCnt)
                    countQ[wIdx] <= wVal[15:0];
                if (wAddr == paired_timer_pkg::IRQ_MASK)
                    maskQ <= wVal[3:0];
                if (wAddr == paired_timer_pkg::IRQ_PRIO)
                    prioQ <= wVal[11:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sticky status: read clears, a coincident match still sets
    // ------------------------------------------------------------------
    // One read clears every flag
    wire [3:0] statusClr = (doRead && rStatus) ? 4'hF : 4'h0;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            statusQ <= 4'h0;
        end else begin
            statusQ <= (statusQ & ~statusClr) | matchEv;
        end
    end

    // ------------------------------------------------------------------
    // Converter trigger: pair A upper timer match only, one-cycle pulse
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            adcQ <= 1'b0;
        end else begin
            adcQ <= matchEv[1];
        end
    end
    // Output straight from a flop: no glitch
    assign adcTrigger = adcQ;

    // ------------------------------------------------------------------
    // Interrupt: level while any enabled flag is set; joined pairs use
    // the upper timer's enable and priority
    // ------------------------------------------------------------------
    wire [3:0] pending = statusQ & maskQ;
    assign irq = |pending;

    // Highest priority among pending sources, for the interrupt controller
    always_comb begin
        irqPriority = 3'd0;
        for (int i = 0; i < 4; i++) begin
            // Ties keep the lower timer
            if (pending[i] && (prioQ[3*i +: 3] > irqPriority))
                irqPriority = prioQ[3*i +: 3];
        end
    end

endmodule // paired_timer_32bit

// File: rtl/paired_timer_pkg.sv
/*
 * Package for the paired 32-bit timer block: register byte offsets,
 * control field positions, reset values and timing constants.
 * Assumes an AXI4-Lite master with 32-bit data and one clock (mclk).
 */
// Notes on behaviour
// - Each pair runs as two 16-bit or one 32-bit.
// - Lower timer is low word, upper is high.
// - Paired mode ignores upper control register entirely.
// - Paired uses lower clock/gate, upper interrupt flag.
// - Control bit 3 of lower selects pairing.
// - Two-bit prescaler; lower one rules when paired.
// - Clock source and gate bits; external input pin.
// - Paired period: upper high word, lower low.
// - Paired interrupt on full 32-bit period match.
// - Bit 15 starts timer; lower starts pair.
// - Count registers: upper high word, lower low.
// - Split timers support all synchronous 16-bit modes.
// - Converter trigger only from pair A upper/joined.
// - Each timer: sync timer/counter, gate, prescale, interrupt.
// - Gated operation; keeps running in idle and sleep.
// - Per-timer interrupt enable and three-bit priority.
package paired_timer_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses, index = timer 0..3 (A lo, A hi, B lo, B hi)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_BASE   = 8'h00;  // Control, +4 per timer
    localparam logic [7:0] PERIOD_BASE = 8'h10;  // Period, +4 per timer
    localparam logic [7:0] COUNT_BASE  = 8'h20;  // Count, +4 per timer
    localparam logic [7:0] IRQ_STATUS  = 8'h30;  // Sticky match flags
    localparam logic [7:0] IRQ_MASK    = 8'h34;  // Enables, same layout
    localparam logic [7:0] IRQ_PRIO    = 8'h38;  // 3 bits per timer
    localparam logic [7:0] ADDR_TOP    = 8'h3C;  // First unmapped offset

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int ON_BIT    = 15;  // Timer on
    localparam int GATE_BIT  = 6;   // Gate mode
    localparam int PS_HI     = 5;   // Prescale select high
    localparam int PS_LO     = 4;   // Prescale select low
    localparam int JOIN_BIT  = 3;   // Pair join (lower timers only)
    localparam int SRC_BIT   = 1;   // Clock source: 1 = external input

    // ------------------------------------------------------------------
    // Reset values and misc
    // ------------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] CTRL_MASK    = 16'h807A;  // Writable control bits
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;

    // Prescale terminal counts (ratio minus one) for select 0..3 (1, 8, 64, 256)
    localparam logic [7:0] PS_DIV1   = 8'h00;
    localparam logic [7:0] PS_DIV8   = 8'h07;
    localparam logic [7:0] PS_DIV64  = 8'h3F;
    localparam logic [7:0] PS_DIV256 = 8'hFF;

endpackage

// File: tb/ext_pin_model.sv
/*
 * Model of the pins outside the timer block: external count and gate.
 * Assumes the bench calls its tasks; pins idle low between uses.
 */
module ext_pin_model (
    // Clock
    input  wire logic       mclk,
    // Pins toward the block
    output logic      [3:0] extCount,
    output logic      [3:0] extGate
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle low from time zero
    initial begin
        extCount = '0;
        extGate  = '0;
    end

    // Slow pulses, so the block's synchroniser sees every edge
    task automatic pulse(input int i, input int k);
        repeat (k) begin
            @(posedge mclk);
            extCount[i] <= 1'b1;
            repeat (4) @(posedge mclk);
            extCount[i] <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask

    // Gate opened for a number of cycles, then closed again
    task automatic gate(input int i, input int cycles);
        @(posedge mclk);
        extGate[i] <= 1'b1;
        repeat (cycles) @(posedge mclk);
        extGate[i] <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
endmodule // ext_pin_model

// File: tb/paired_timer_asserts.sv
/*
 * Checker for the paired timer: bus answers and interrupt priority.
 * Assumes it is bound to the top module and sees only its ports.
 */
module paired_timer_asserts (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // Bus
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [7:0]  araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    // Events
    input wire logic        adcTrigger,
    input wire logic        irq,
    input wire logic [2:0]  irqPriority
);
    timeunit 1ns;
    timeprecision 1ps;

    // One domain, so one clock and one reset for all
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
        else $error("write response not one cycle after both halves");
    a_write_once: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    a_write_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data not one cycle after address");
    a_read_once: assert property (rvalid && rready |=> !rvalid)
        else $error("read data repeated");
    a_read_refuse: assert property (rvalid |-> !arready)
        else $error("read address taken while data pending");
    a_bad_addr: assert property (arvalid && arready && (araddr >= 8'h3C || araddr[1:0] != 2'h0)
        |=> rresp == paired_timer_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_prio_idle: assert property (!irq |-> irqPriority == 3'h0)
        else $error("priority shown with nothing pending");

    // Main scenarios reached
    cover property (adcTrigger);
    cover property (irq && irqPriority == 3'h5);
    cover property (rvalid && rresp == paired_timer_pkg::RESP_SLVERR);
endmodule // paired_timer_asserts

bind paired_timer_32bit paired_timer_asserts u_chk (
    .mclk, .rstn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .adcTrigger, .irq, .irqPriority
);

// File: tb/tb_top.sv
/*
 * Bench for the paired timer: register rows, then timer cases.
 * Assumes the checker is bound in and the pin model drives the pins.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        mclk = '0;
    logic        rstn = '0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0]  wstrb = 4'hF;  // Full words only
    logic        awready, wready, bvalid, arready, rvalid, adcTrigger, irq;
    logic [1:0]  bresp, rresp, rs;
    logic [2:0]  irqPriority;
    logic [3:0]  extCount, extGate;
    int          miscompares = 0, testsRun = 0, n;
    localparam int DIV [4] = '{1, 8, 64, 256};  // Prescale ratios

    // Row: write or read, address, data written or expected, response
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [1:0]  resp;
    } row_s;
    localparam row_s ROWS [10] = '{
        '{1'h1, 8'h04, 32'h0000_7FFF, 2'h0}, '{1'h0, 8'h04, 32'h0000_007A, 2'h0},
        '{1'h1, 8'h14, 32'h0000_1234, 2'h0}, '{1'h0, 8'h14, 32'h0000_1234, 2'h0},
        '{1'h0, 8'h00, 32'h0000_0000, 2'h0}, '{1'h0, 8'h10, 32'h0000_FFFF, 2'h0},
        '{1'h0, 8'h2C, 32'h0000_0000, 2'h0}, '{1'h0, 8'h3C, 32'h0000_0000, 2'h2},
        '{1'h1, 8'h40, 32'h0000_0005, 2'h2}, '{1'h0, 8'h02, 32'h0000_0000, 2'h2}};

    paired_timer_32bit u_dut (
        .mclk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .extCount, .extGate, .adcTrigger, .irq, .irqPriority);
    ext_pin_model u_ext (.mclk, .extCount, .extGate);

    // 125 MHz clock
    initial forever #4 mclk = ~mclk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Both write halves offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_t(input logic [7:0] a);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd_t(a);
        chk(nm, e, rd);
    endtask

    // Cycles up to the next trigger pulse; the watchdog bounds it
    task automatic waitTrig();
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!adcTrigger);
    endtask

    task automatic summarize();
        if (miscompares == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog, well past the longest expected run
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        summarize();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        chk("irq after reset", 32'h0, {31'h0, irq});
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) wr(ROWS[i].addr, ROWS[i].data);
            else rd_t(ROWS[i].addr);
            if (!ROWS[i].wr) chk("row data", ROWS[i].data, rd);
            chk("row resp", {30'h0, ROWS[i].resp}, {30'h0, rs});
        end
        // Every prescale code on the triggering upper timer
        wr(8'h14, 32'h0000_0001);
        wr(8'h34, 32'h0000_0002);
        wr(8'h38, 32'h0000_0028);
        for (int ps = 0; ps < 4; ps++) begin
            wr(8'h04, {16'h0, 1'b1, 9'h0, 2'(ps), 4'h0});
            waitTrig();
            waitTrig();
            chk("trigger interval", 32'(2 * DIV[ps]), 32'(n));
            chk("irq set", 32'h1, {31'h0, irq});
            chk("irq priority", 32'h5, {29'h0, irqPriority});
            wr(8'h04, 32'h0);
            rc(8'h30, 32'h2, "status timer1");
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        // Joined pair; upper control holds a decoy setting
        wr(8'h00, 32'h0000_0008);
        wr(8'h04, 32'h0000_8030);
        wr(8'h20, 32'h0000_FFFE);
        wr(8'h24, 32'h0000_0000);
        wr(8'h10, 32'h0000_0001);
        wr(8'h14, 32'h0000_0001);
        wr(8'h00, 32'h0000_8038);
        waitTrig();
        wr(8'h00, 32'h0000_0008);
        chk("joined run length", 32'h1, 32'(n > 900 && n < 1100));
        rc(8'h20, 32'h0, "joined low count");
        rc(8'h24, 32'h0, "joined high count");
        rc(8'h30, 32'h2, "joined status");
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        // External count on the lower timer of pair B
        wr(8'h18, 32'h0000_0001);
        wr(8'h08, 32'h0000_8002);
        u_ext.pulse(2, 3);
        rc(8'h28, 32'h1, "external count");
        wr(8'h08, 32'h0);
        rc(8'h30, 32'h4, "external status");
        // Gate on the upper timer of pair B, its match masked
        wr(8'h1C, 32'h0);
        wr(8'h0C, 32'h0000_8040);
        repeat (20) @(posedge mclk);
        rc(8'h30, 32'h0, "closed gate status");
        u_ext.gate(3, 10);
        chk("masked irq", 32'h0, {31'h0, irq});
        rc(8'h30, 32'h8, "open gate status");
        wr(8'h0C, 32'h0);
        // Pair B joined: only the upper flag may set
        wr(8'h08, 32'h0000_0008);
        wr(8'h08, 32'h0000_8008);
        wr(8'h08, 32'h0000_0008);
        rc(8'h30, 32'h8, "pair B joined status");
        wr(8'h08, 32'h0);
        // Second reset while a timer runs
        wr(8'h04, 32'h0000_8000);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rc(8'h04, 32'h0, "control after reset");
        rc(8'h14, 32'h0000_FFFF, "period after reset");
        summarize();
    end
endmodule // tb_top
